// ===== asc_pkg.sv
// Constants, types and helpers shared by the converter control block
package asc_pkg;

  // Register map, byte offsets on the plain register port
  localparam logic [1:0] ASC_STATCTL_OFS = 2'h0;
  localparam logic [1:0] ASC_RESULT_OFS = 2'h1;

  // Status/control field positions
  localparam int ASC_DONE_BIT = 7;
  localparam int ASC_RCSEL_BIT = 6;
  localparam int ASC_PWR_BIT = 5;
  localparam int ASC_CH_MSB = 2;

  // Reset values
  localparam logic [7:0] ASC_STATCTL_RST = 8'h00;
  localparam logic [7:0] ASC_RESULT_RST = 8'h00;

  // Conversion timing in conversion clock ticks, first trial DAC code, minimum conversion clock in kHz
  localparam int ASC_CONV_TICKS = 32;
  localparam logic [4:0] ASC_LAST_TICK = 5'h1f;
  localparam logic [4:0] ASC_FIRST_TRIAL = 5'h01;
  localparam logic [4:0] ASC_LAST_TRIAL = 5'h08;
  localparam logic [7:0] ASC_TRIAL_MSB = 8'h80;
  localparam int ASC_MIN_CONV_KHZ = 1000;

  // Channel codes
  localparam logic [2:0] ASC_CH_REF_HIGH = 3'h4;
  localparam logic [2:0] ASC_CH_RESERVED = 3'h7;

  // Settling after leaving stop, time and derived cycle count
  localparam int ASC_CLK_KHZ = 20000;
  localparam int ASC_STOP_SETTLE_US = 100;
  localparam int ASC_STOP_SETTLE_CYC = (ASC_CLK_KHZ * ASC_STOP_SETTLE_US + 999) / 1000;
  localparam logic [11:0] ASC_SETTLE_LAST = 12'(ASC_STOP_SETTLE_CYC - 1);

  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_RUN = 4'b0010,
    ST_STOP = 4'b0100,
    ST_WAKE = 4'b1000
  } asc_state_t;

  // Port C pin shared with a channel code; zero for internal channels
  function automatic logic [7:0] asc_pin_mask(input logic [2:0] ch);
    case (ch)
      3'h0: asc_pin_mask = 8'h40;
      3'h1: asc_pin_mask = 8'h20;
      3'h2: asc_pin_mask = 8'h10;
      3'h3: asc_pin_mask = 8'h08;
      3'h4: asc_pin_mask = 8'h80;
      default: asc_pin_mask = 8'h00;
    endcase
  endfunction : asc_pin_mask

endpackage : asc_pkg

// ===== asc_sar_if.sv
// Signals between the control logic and the approximation engine
`timescale 1ns/1ps
interface asc_sar_if;
  logic run;
  logic start;
  logic tick;
  logic comp;
  logic sample;
  logic done;
  logic [7:0] dac;
  logic [7:0] result;

  modport engine (input run, start, tick, comp, output sample, done, dac, result);
  modport ctl (output run, start, tick, comp, input sample, done, dac, result);
endinterface : asc_sar_if

// ===== asc_conv_tick.sv
// Conversion clock select: bus clock or synchronised RC oscillator edges
`timescale 1ns/1ps
module asc_conv_tick
  import asc_pkg::*;
(
  input wire logic mclk, // Bus clock
  input wire logic rstn, // Sync reset, low
  input wire logic rc_clock_select, // One picks RC oscillator
  input wire logic rc_osc, // RC oscillator level
  output logic tick // Conversion clock enable
);

  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync1_reg <= rc_osc;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // RC edges are unrelated to mclk, so software must poll done
  assign tick = rc_clock_select ? (sync2_reg & ~prev_reg) : 1'b1;

endmodule : asc_conv_tick

// ===== asc_sar_engine.sv
// Successive approximation sequencer, 32 conversion ticks per result
`timescale 1ns/1ps
module asc_sar_engine
  import asc_pkg::*;
(
  input wire logic mclk, // Bus clock
  input wire logic rstn, // Sync reset, low
  asc_sar_if.engine sar // Control side
);

  logic active_reg;
  logic [4:0] cnt_reg;
  logic [7:0] acc_reg;
  logic [7:0] mask_reg;
  logic [7:0] dac_reg;
  logic step;
  logic trial;
  logic [7:0] acc_next;

  assign step = active_reg & sar.tick & ~sar.start;
  assign trial = step && cnt_reg >= ASC_FIRST_TRIAL && cnt_reg <= ASC_LAST_TRIAL;
  assign acc_next = sar.comp ? (acc_reg | mask_reg) : acc_reg;
  assign sar.sample = step && cnt_reg == 5'h00;
  assign sar.done = step && cnt_reg == ASC_LAST_TICK;
  assign sar.dac = dac_reg;
  assign sar.result = acc_reg;

  always_ff @(posedge mclk) begin
    if (!rstn || !sar.run) begin
      active_reg <= 1'b0;
      cnt_reg <= 5'h00;
      acc_reg <= 8'h00;
      mask_reg <= 8'h00;
      dac_reg <= 8'h00;
    end else if (sar.start) begin
      active_reg <= 1'b1;
      cnt_reg <= 5'h00;
    end else if (step) begin
      cnt_reg <= cnt_reg + 5'h01; // Wraps to 0 for continuous runs
      if (sar.sample) begin
        acc_reg <= 8'h00;
        mask_reg <= ASC_TRIAL_MSB;
        dac_reg <= ASC_TRIAL_MSB;
      end else if (trial) begin
        acc_reg <= acc_next;
        mask_reg <= mask_reg >> 1;
        dac_reg <= acc_next | (mask_reg >> 1);
      end
    end
  end

endmodule : asc_sar_engine

// ===== asc_ctrl.sv
// Converter control: registers, sequencing, stop handling, port C sharing
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module asc_ctrl
  import asc_pkg::*;
(
  input wire logic mclk, // 20 MHz bus clock
  input wire logic rstn, // Sync reset, low
  input wire logic [1:0] reg_addr, // Register offset
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, next cycle
  input wire logic rc_osc, // RC oscillator level
  input wire logic stop_mode, // High while in stop
  input wire logic ana_comp, // Input above DAC level
  output logic [2:0] ana_select, // Multiplexer channel
  output logic ana_sample, // Sample pulse
  output logic [7:0] ana_dac, // DAC trial code
  output logic ana_power, // Analog power enable
  input wire logic [7:0] pc_ddr_in, // Port C direction bits
  output logic [7:0] pc_ddr_out, // Direction with overrides
  input wire logic [7:0] pc_pin_in, // Port C data read value
  output logic [7:0] pc_read_out // Data read with masking
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic done_reg;
  logic done_next;
  logic rc_sel_reg;
  logic pwr_reg;
  logic [2:0] chan_reg;
  logic [7:0] result_reg;
  logic [7:0] result_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] ddr_reg;
  logic [7:0] pcrd_reg;
  logic [11:0] settle_reg;
  logic [11:0] settle_next;
  asc_state_t state_reg;
  asc_state_t state_next;

  logic wr_ctl;
  logic rd_ctl;
  logic rd_res;
  logic settled;
  logic enter_run;
  logic conv_tick;
  logic [7:0] statctl_view;
  logic [7:0] shared_mask;

  asc_sar_if sar ();

  ////////////////////////////////////////////////////////////////////////////
  // Register port decoding

  assign wr_ctl = reg_wr && reg_addr == ASC_STATCTL_OFS;
  assign rd_ctl = reg_rd && reg_addr == ASC_STATCTL_OFS;
  assign rd_res = reg_rd && reg_addr == ASC_RESULT_OFS;

  assign statctl_view = {done_reg, rc_sel_reg, pwr_reg, 2'b00, chan_reg};

  // Unmapped offsets read as zero
  assign rdata_next = rd_ctl ? statctl_view :
                      rd_res ? result_reg : 8'h00;

  assign reg_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Control fields

  // Done flag is read-only; writes only clear it
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rc_sel_reg <= ASC_STATCTL_RST[ASC_RCSEL_BIT];
      pwr_reg <= ASC_STATCTL_RST[ASC_PWR_BIT];
      chan_reg <= ASC_STATCTL_RST[ASC_CH_MSB:0];
    end else if (wr_ctl) begin
      rc_sel_reg <= reg_wdata[ASC_RCSEL_BIT];
      pwr_reg <= reg_wdata[ASC_PWR_BIT];
      chan_reg <= reg_wdata[ASC_CH_MSB:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Done flag and result

  // Completion wins over a clear in the same cycle, so no result is lost
  assign done_next = sar.done ? 1'b1 :
                     (wr_ctl || rd_res) ? 1'b0 :
                     done_reg;

  // Reserved channel forces a zero result
  assign result_next = !sar.done ? result_reg :
                       (chan_reg == ASC_CH_RESERVED) ? 8'h00 :
                       sar.result;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      done_reg <= ASC_STATCTL_RST[ASC_DONE_BIT];
      result_reg <= ASC_RESULT_RST;
      rdata_reg <= 8'h00;
    end else begin
      done_reg <= done_next;
      result_reg <= result_next;
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power and stop sequencing

  assign settled = settle_reg == ASC_SETTLE_LAST;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (stop_mode) begin
          state_next = ST_STOP;
        end else if (pwr_reg || (wr_ctl && reg_wdata[ASC_PWR_BIT])) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        // Wait and halt are not inputs here: conversions carry on
        if (stop_mode) begin
          state_next = ST_STOP;
        end else if (!pwr_reg) begin
          state_next = ST_OFF;
        end
      end
      ST_STOP: begin
        if (!stop_mode) begin
          state_next = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (stop_mode) begin
          state_next = ST_STOP;
        end else if (settled) begin
          state_next = pwr_reg ? ST_RUN : ST_OFF;
        end
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
  end

  // Settling counter only runs while waking from stop
  assign settle_next = (state_reg == ST_WAKE) ? settle_reg + 12'h001 : 12'h000;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_reg <= ST_OFF;
      settle_reg <= 12'h000;
    end else begin
      state_reg <= state_next;
      settle_reg <= settle_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Engine hookup

  assign enter_run = state_reg != ST_RUN && state_next == ST_RUN;

  // Run follows the next state, so a powering write starts at once, not twice
  assign sar.run = state_next == ST_RUN;
  // A powering write restarts on the new channel, also discarding a half-done result
  assign sar.start = (wr_ctl && reg_wdata[ASC_PWR_BIT]) || enter_run;
  assign sar.tick = conv_tick;
  assign sar.comp = ana_comp;

  asc_conv_tick u_tick (
    .mclk(mclk),
    .rstn(rstn),
    .rc_clock_select(rc_sel_reg),
    .rc_osc(rc_osc),
    .tick(conv_tick)
  );

  asc_sar_engine u_sar (
    .mclk(mclk),
    .rstn(rstn),
    .sar(sar.engine)
  );

  assign ana_select = chan_reg;
  assign ana_sample = sar.sample;
  assign ana_dac = sar.dac;
  // Analog section powered down in stop
  assign ana_power = pwr_reg && state_reg != ST_STOP;

  ////////////////////////////////////////////////////////////////////////////
  // Port C sharing

  assign shared_mask = pwr_reg ? asc_pin_mask(chan_reg) : 8'h00;

  // Registered for one cycle; the port logic sees both a cycle late
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ddr_reg <= 8'h00;
      pcrd_reg <= 8'h00;
    end else begin
      ddr_reg <= pc_ddr_in & ~shared_mask;
      pcrd_reg <= pc_pin_in & ~shared_mask;
    end
  end

  assign pc_ddr_out = ddr_reg;
  assign pc_read_out = pcrd_reg;

endmodule : asc_ctrl

// ===== asc_ctrl_properties.sv
// Port assertions for the converter control block
`timescale 1ns/1ps
module asc_ctrl_properties
  import asc_pkg::*;
(
  input wire logic mclk, // Clock
  input wire logic rstn, // Reset, low
  input wire logic [1:0] reg_addr, // Offset
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic stop_mode, // Stop level
  input wire logic [2:0] ana_select, // Channel
  input wire logic ana_sample, // Sample pulse
  input wire logic ana_power, // Analog power
  input wire logic [7:0] pc_ddr_in, // Direction in
  input wire logic [7:0] pc_ddr_out, // Direction out
  input wire logic [7:0] pc_pin_in, // Data in
  input wire logic [7:0] pc_read_out // Data out
);
  logic wr0, rc_q, armed_q;
  logic [4:0] gap_q;
  logic [7:0] pin_m;
  assign wr0 = reg_wr && reg_addr == ASC_STATCTL_OFS;
  // Own pin table, so a wrong shared helper still shows
  assign pin_m = ana_select == 3'h4 ? 8'h80 : ana_select[2] ? 8'h00 : 8'h40 >> ana_select;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Period only judged between samples on the bus clock
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rc_q <= 1'b0;
      armed_q <= 1'b0;
      gap_q <= 5'h00;
    end else begin
      if (wr0) begin
        rc_q <= reg_wdata[ASC_RCSEL_BIT];
      end
      armed_q <= ana_sample && !wr0 ? !rc_q : armed_q && !wr0 && !stop_mode;
      gap_q <= ana_sample ? 5'h00 : gap_q + 5'h01;
    end
  end
  ////////////////////////////////////////
  restart_seq_a: assert property (
    wr0 && reg_wdata[ASC_PWR_BIT] && !reg_wdata[ASC_RCSEL_BIT] && !stop_mode |=> ana_sample)
    else $error("No sample after control write");
  repeat_due_a: assert property (
    armed_q && gap_q == 5'h1f && !wr0 && !stop_mode |-> ana_sample)
    else $error("Repeat conversion late");
  early_sample_a: assert property (ana_sample && armed_q |-> gap_q == 5'h1f)
    else $error("Conversion shorter than 32");
  stop_halt_a: assert property (stop_mode && $past(stop_mode) |-> !ana_power && !ana_sample)
    else $error("Activity in stop");
  sample_power_a: assert property (ana_sample |-> ana_power)
    else $error("Sample while unpowered");
  ctl_readback_a: assert property (
    wr0 ##2 (reg_rd && reg_addr == ASC_STATCTL_OFS) |=>
    reg_rdata[6:0] == 7'($past(reg_wdata, 3) & 8'h67))
    else $error("Control readback wrong");
  pin_read_a: assert property (
    $past(ana_power) |-> pc_read_out == ($past(pc_pin_in) & ~$past(pin_m)))
    else $error("Shared pin read not masked");
  pin_dir_a: assert property (
    $past(ana_power) |-> pc_ddr_out == ($past(pc_ddr_in) & ~$past(pin_m)))
    else $error("Shared pin direction not forced");
  cover property (armed_q && ana_sample);
  cover property (stop_mode ##1 !stop_mode);
  cover property (reg_rd && reg_addr == ASC_RESULT_OFS);
endmodule : asc_ctrl_properties

bind asc_ctrl asc_ctrl_properties u_props (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .stop_mode, .ana_select, .ana_sample, .ana_power, .pc_ddr_in,
  .pc_ddr_out, .pc_pin_in, .pc_read_out);

// ===== tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_top;
  import asc_pkg::*;
  logic mclk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic rc_osc = 1'b0, stop_mode = 1'b0, rc_on = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00, pc_ddr_in = 8'hff, pc_pin_in = 8'hff, level = 8'h5a;
  logic [3:0] rc_cnt = 4'h0;
  logic [7:0] rv, reg_rdata, ana_dac, pc_ddr_out, pc_read_out;
  logic [2:0] ana_select;
  logic ana_sample, ana_power, ana_comp;
  logic [7:0] pin_m [8] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h80, 8'h00, 8'h00, 8'h00};
  int num_errors = 0;
  int n_checks = 0;

  always #25 mclk = ~mclk;
  // Ideal comparator on a steady input level
  assign ana_comp = ana_dac <= level;
  // Slow oscillator, 14 bus cycles a period, only while enabled
  always @(posedge mclk) begin
    if (rc_on) begin
      rc_cnt <= rc_cnt == 4'h6 ? 4'h0 : rc_cnt + 4'h1;
      rc_osc <= rc_osc ^ (rc_cnt == 4'h6);
    end
  end

  asc_ctrl dut (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rc_osc,
    .stop_mode, .ana_comp, .ana_select, .ana_sample, .ana_dac, .ana_power, .pc_ddr_in,
    .pc_ddr_out, .pc_pin_in, .pc_read_out);
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic wait_done(input int lim);
    for (int i = 0; i < lim; i++) begin
      rd(2'h0, rv);
      if (rv[7] === 1'b1) break;
    end
    chk(rv & 8'h80, 8'h80);
  endtask : wait_done

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    complete_run();
  end

  initial begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    rd(2'h0, rv);
    chk(rv, ASC_STATCTL_RST);
    rd(2'h2, rv);
    chk(rv, 8'h00);
    for (int ch = 0; ch < 8; ch++) begin
      wr(2'h0, 8'h20 | 8'(ch));
      repeat (2) @(posedge mclk);
      #1 chk(pc_ddr_out, ~pin_m[ch]);
      chk(pc_read_out, ~pin_m[ch]);
      chk({5'h00, ana_select}, 8'(ch));
      rd(2'h0, rv);
      chk(rv, 8'h20 | 8'(ch));
      wait_done(40);
      rd(2'h1, rv);
      chk(rv, ch == 7 ? 8'h00 : level);
      rd(2'h0, rv);
      chk(rv & 8'h80, 8'h00);
    end
    wr(2'h0, 8'h21);
    wait_done(40);
    level = 8'h3c;
    repeat (70) @(posedge mclk);
    rd(2'h0, rv);
    chk(rv & 8'h80, 8'h80);
    wr(2'h1, 8'haa);
    rd(2'h1, rv);
    chk(rv, 8'h3c);
    wr(2'h0, 8'h80);
    rd(2'h0, rv);
    chk(rv, 8'h00);
    chk(pc_ddr_out, 8'hff);
    level = 8'h5a;
    wr(2'h0, 8'h22);
    repeat (10) @(posedge mclk);
    stop_mode <= 1'b1;
    repeat (50) @(posedge mclk);
    #1 chk({7'h00, ana_power}, 8'h00);
    stop_mode <= 1'b0;
    repeat (1900) @(posedge mclk);
    rd(2'h0, rv);
    chk(rv & 8'h80, 8'h00);
    wait_done(300);
    rd(2'h1, rv);
    chk(rv, level);
    wr(2'h0, 8'h62);
    repeat (100) @(posedge mclk);
    rd(2'h0, rv);
    chk(rv & 8'h80, 8'h00);
    rc_on <= 1'b1;
    wait_done(400);
    rd(2'h1, rv);
    chk(rv, level);
    complete_run();
  end
endmodule : tb_top
